// ==== csc_config_start.sv ====
// Purpose: decides how and when configuration begins and restarts
// Assumes: straps static; status line is open drain with external pull-up
// Notes:   registers on a plain strobe port, read data one cycle later
//
// Overview of operation
// - strap high 12 ms, low 100 ms
// - pull-ups off when strap high, before user
// - scheme from three-bit scheme select strap
// - control low in user: clear, reset, hi-z
// - control back high starts new configuration
// - configure only while control high; jtag ignores
// - status low at power-up until delay ends
// - outside low on status during configuration: error state
`timescale 1ns/1ps
module csc_config_start
  import csc_pkg::*;
#(
  parameter int unsigned POR_FAST = csc_pkg::POR_FAST_CYC,
  parameter int unsigned POR_SLOW = csc_pkg::POR_SLOW_CYC,
  parameter int unsigned DEB      = csc_pkg::DEB_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        por_fast_sel,
  input  wire logic        pullup_off_sel,
  input  wire logic [2:0]  scheme_select,
  input  wire logic        cfg_ctrl_n,
  input  wire logic        jtag_mode,
  input  wire logic        cfg_finish,
  input  wire logic        status_in,
  output logic             status_out,
  output logic             status_oe,
  output logic             cfg_enable,
  output logic             cfg_clear,
  output logic             io_hiz,
  output logic             pullup_en,
  output logic [2:0]       cfg_scheme,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  output logic             irq
);
  import csc_pkg::*;

  csc_state_e           state;
  csc_state_e           next_state;
  logic [POR_CNT_W-1:0] por_cnt;
  logic [POR_CNT_W-1:0] next_por_cnt;
  logic [POR_CNT_W-1:0] por_last;
  csc_strap_s           strap;
  csc_strap_s           next_strap;
  logic                 ctrl_db;
  logic                 ctrl_ok;
  logic                 ext_low;
  logic [EVT_W-1:0]     evt_status;
  logic [EVT_W-1:0]     next_evt_status;
  logic [EVT_W-1:0]     evt_mask;
  logic [EVT_W-1:0]     next_evt_mask;
  logic [EVT_W-1:0]     evt;
  logic [31:0]          next_rd_data;

  csc_debounce #(
    .STABLE (DEB)
  ) u_ctrl_deb (
    .clk  (clk),
    .srst (srst),
    .din  (cfg_ctrl_n),
    .dout (ctrl_db)
  );

  // jtag programming does not look at the control line
  assign ctrl_ok  = ctrl_db | jtag_mode;
  assign por_last = strap.por_fast ? POR_CNT_W'(POR_FAST - 1)
                                   : POR_CNT_W'(POR_SLOW - 1);
  // only an outside driver can pull the line low while we release it
  assign ext_low  = !status_in && !status_oe;

  always_comb begin
    next_state   = state;
    next_por_cnt = por_cnt;
    next_strap   = strap;
    case (state)
      CSC_POR: begin
        next_strap.por_fast   = por_fast_sel;
        next_strap.pullup_off = pullup_off_sel;
        next_por_cnt          = por_cnt + 1'b1;
        if (por_cnt == por_last) begin
          next_por_cnt = '0;
          next_state   = ctrl_ok ? CSC_CONFIG : CSC_CLEAR;
          if (ctrl_ok) begin
            next_strap.scheme = scheme_select;
          end
        end
      end
      CSC_CLEAR: begin
        if (ctrl_ok) begin
          next_state        = CSC_CONFIG;
          next_strap.scheme = scheme_select;
        end
      end
      CSC_CONFIG: begin
        if (!ctrl_ok) begin
          next_state = CSC_CLEAR;
        end else if (ext_low) begin
          next_state = CSC_ERROR;
        end else if (cfg_finish) begin
          next_state = CSC_USER;
        end
      end
      CSC_USER: begin
        if (!ctrl_ok) begin
          next_state = CSC_CLEAR;
        end
      end
      CSC_ERROR: begin
        if (!ctrl_ok) begin
          next_state = CSC_CLEAR;
        end
      end
      default: begin
        next_state = CSC_POR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= CSC_POR;
      por_cnt <= '0;
      strap   <= STRAP_RESET;
    end else begin
      state   <= next_state;
      por_cnt <= next_por_cnt;
      strap   <= next_strap;
    end
  end

  // status line held low through power-up, reset and error
  assign status_out = 1'b0;
  assign status_oe  = (state == CSC_POR) || (state == CSC_CLEAR) || (state == CSC_ERROR);
  assign cfg_enable = (state == CSC_CONFIG);
  assign cfg_clear  = (state == CSC_CLEAR);
  assign io_hiz     = (state != CSC_USER);
  // after user mode starts the design owns the pull-ups
  assign pullup_en  = (state != CSC_USER) && !strap.pullup_off;
  assign cfg_scheme = strap.scheme;

  always_comb begin
    evt                = '0;
    evt[EVT_POR_DONE]  = (state == CSC_POR) && (next_state != CSC_POR);
    evt[EVT_CLEARED]   = (state != CSC_CLEAR) && (next_state == CSC_CLEAR);
    evt[EVT_STARTED]   = (state != CSC_CONFIG) && (next_state == CSC_CONFIG);
    evt[EVT_USER]      = (state != CSC_USER) && (next_state == CSC_USER);
    evt[EVT_ERROR]     = (state != CSC_ERROR) && (next_state == CSC_ERROR);
  end

  always_comb begin
    next_evt_status = evt_status;
    next_evt_mask   = evt_mask;
    next_rd_data    = '0;
    if (wr_en && addr == OFS_EVT_STATUS) begin
      next_evt_status = evt_status & ~wr_data[EVT_W-1:0];
    end
    // a new event in the clearing cycle survives
    next_evt_status = next_evt_status | evt;
    if (wr_en && addr == OFS_EVT_MASK) begin
      next_evt_mask = wr_data[EVT_W-1:0];
    end
    if (rd_en) begin
      case (addr)
        OFS_EVT_STATUS: next_rd_data[EVT_W-1:0] = evt_status;
        OFS_EVT_MASK:   next_rd_data[EVT_W-1:0] = evt_mask;
        OFS_STATE: begin
          next_rd_data[STATE_POS+:5]  = state;
          next_rd_data[SCHEME_POS+:3] = strap.scheme;
          next_rd_data[STRAP_POS]     = strap.por_fast;
          next_rd_data[STRAP_POS+1]   = strap.pullup_off;
          next_rd_data[STRAP_POS+2]   = ctrl_db;
        end
        default:        next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_status <= EVT_RESET;
      evt_mask   <= EVT_RESET;
      rd_data    <= '0;
    end else begin
      evt_status <= next_evt_status;
      evt_mask   <= next_evt_mask;
      rd_data    <= next_rd_data;
    end
  end

  assign irq = |(evt_status & evt_mask);

  property p_por_len;
    @(posedge clk) disable iff (srst)
      (state == CSC_POR && next_state != CSC_POR) |-> (por_cnt == (strap.por_fast ? POR_FAST - 1 : POR_SLOW - 1));
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-up delay wrong length");

  property p_pullup;
    @(posedge clk) disable iff (srst)
      (state == CSC_CONFIG) |-> (pullup_en == !pullup_off_sel);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

  property p_scheme;
    @(posedge clk) disable iff (srst)
      (evt[EVT_STARTED]) |=> (cfg_scheme == $past(scheme_select));
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme not captured");

  property p_user_clear;
    @(posedge clk) disable iff (srst)
      (state == CSC_USER && !ctrl_db && !jtag_mode) |=> (cfg_clear && io_hiz && status_oe);
  endproperty
  a_user_clear: assert property (p_user_clear) else $error("user mode not cleared");

  property p_restart;
    @(posedge clk) disable iff (srst)
      (state == CSC_CLEAR && ctrl_db) |=> cfg_enable;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after control high");

  property p_cfg_needs_ctrl;
    @(posedge clk) disable iff (srst)
      cfg_enable |-> $past(ctrl_db || jtag_mode);
  endproperty
  a_cfg_needs_ctrl: assert property (p_cfg_needs_ctrl) else $error("configuring with control low");

  property p_por_status;
    @(posedge clk) disable iff (srst)
      (state == CSC_POR) |-> (status_oe && !status_out && !cfg_enable);
  endproperty
  a_por_status: assert property (p_por_status) else $error("status released during power-up");

  property p_error;
    @(posedge clk) disable iff (srst)
      (cfg_enable && ctrl_ok && !status_in) |=> (state == CSC_ERROR) ##1 status_oe;
  endproperty
  a_error: assert property (p_error) else $error("outside low not seen as error");

  property p_debounce;
    @(posedge clk) disable iff (srst)
      $fell(ctrl_db) |-> $past(cfg_ctrl_n, 3) == 1'b0;
  endproperty
  a_debounce: assert property (p_debounce) else $error("control acted on without filter");

  property p_irq;
    @(posedge clk) disable iff (srst)
      $rose(evt_status[EVT_ERROR]) && evt_mask[EVT_ERROR] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked-in event without interrupt");

  property p_clear_pins;
    @(posedge clk) disable iff (srst)
      cfg_clear |-> (io_hiz && status_oe && !cfg_enable);
  endproperty
  a_clear_pins: assert property (p_clear_pins) else $error("clear state leaves pins driven");

  property p_error_hold;
    @(posedge clk) disable iff (srst)
      (state == CSC_ERROR && ctrl_ok) |=> (state == CSC_ERROR);
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error left without control low");

  property p_jtag_keep;
    @(posedge clk) disable iff (srst)
      (cfg_enable && jtag_mode) |=> (state == CSC_CONFIG || state == CSC_USER || state == CSC_ERROR);
  endproperty
  a_jtag_keep: assert property (p_jtag_keep) else $error("control line acted on in jtag mode");

  property p_user_pins;
    @(posedge clk) disable iff (srst)
      (state == CSC_USER) |-> (!pullup_en && !io_hiz && !status_oe);
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("pins not handed over in user mode");

  property p_scheme_hold;
    @(posedge clk) disable iff (srst)
      (state != CSC_POR && !evt[EVT_STARTED]) |=> $stable(cfg_scheme);
  endproperty
  a_scheme_hold: assert property (p_scheme_hold) else $error("scheme changed outside capture");

  // a clear written in the event cycle must not lose the event
  property p_evt_sticky;
    @(posedge clk) disable iff (srst)
      evt[EVT_ERROR] |=> evt_status[EVT_ERROR];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("error event not latched");

  property p_rd_idle;
    @(posedge clk) disable iff (srst)
      !rd_en |=> (rd_data == '0);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read strobe");

  c_user: cover property (@(posedge clk) disable iff (srst) evt[EVT_USER]);
  c_reconfig: cover property (@(posedge clk) disable iff (srst) state == CSC_CLEAR ##1 state == CSC_CONFIG);
  c_error: cover property (@(posedge clk) disable iff (srst) evt[EVT_ERROR]);
  c_jtag: cover property (@(posedge clk) disable iff (srst) cfg_enable && jtag_mode && !ctrl_db);
endmodule // csc_config_start

// ==== csc_debounce.sv ====
// Purpose: two-stage synchroniser plus stability filter for one level
// Assumes: level changes slower than the filter window
// Notes:   output follows only after the input holds for STABLE cycles
`timescale 1ns/1ps
module csc_debounce #(
  parameter int unsigned STABLE = csc_pkg::DEB_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  import csc_pkg::*;

  logic                 sync_a;
  logic                 sync_b;
  logic [DEB_CNT_W-1:0] cnt;
  logic [DEB_CNT_W-1:0] next_cnt;
  logic                 next_dout;

  localparam logic [DEB_CNT_W-1:0] LAST = DEB_CNT_W'(STABLE - 1);

  always_comb begin
    next_cnt  = '0;
    next_dout = dout;
    if (sync_b != dout) begin
      next_cnt = cnt + 1'b1;
      if (cnt == LAST) begin
        next_dout = sync_b;
        next_cnt  = '0;
      end
    end
  end

  // resets high: a released control line is the idle level
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      cnt    <= '0;
      dout   <= 1'b1;
    end else begin
      sync_a <= din;
      sync_b <= sync_a;
      cnt    <= next_cnt;
      dout   <= next_dout;
    end
  end
endmodule // csc_debounce

// ==== csc_host.sv ====
// Purpose: board side of the configuration start control
// Assumes: status wire carries an external pull-up
// Notes:   supplies_ok low stands for a slow supply ramp
`timescale 1ns/1ps
module csc_host (
  input  wire logic supplies_ok,
  input  wire logic ctrl_req_n,
  input  wire logic pull_low,
  input  wire logic status_oe,
  input  wire logic status_out,
  output logic      cfg_ctrl_n,
  output logic      status_in
);
  // control forced low until the supplies settle
  assign cfg_ctrl_n = supplies_ok & ctrl_req_n;
  // open-drain wire: the pull-up wins unless a party pulls it low
  assign status_in  = ~((status_oe & ~status_out) | pull_low);
endmodule // csc_host

// ==== csc_pkg.sv ====
// Purpose: shared constants and types for the configuration start control
// Assumes: 200 MHz clock
// Notes:   long counts are overridable at the top level
package csc_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned POR_FAST_MS    = 12;
  localparam int unsigned POR_SLOW_MS    = 100;
  localparam int unsigned POR_FAST_CYC   = POR_FAST_MS * CLK_MHZ * 1000;
  localparam int unsigned POR_SLOW_CYC   = POR_SLOW_MS * CLK_MHZ * 1000;
  localparam int unsigned DEB_NS         = 1000;
  localparam int unsigned DEB_CYC        = (DEB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POR_CNT_W      = 25;
  localparam int unsigned DEB_CNT_W      = 8;

  localparam logic [7:0] OFS_EVT_STATUS  = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h04;
  localparam logic [7:0] OFS_STATE       = 8'h08;

  localparam int unsigned EVT_W          = 5;
  localparam int unsigned EVT_POR_DONE   = 0;
  localparam int unsigned EVT_CLEARED    = 1;
  localparam int unsigned EVT_STARTED    = 2;
  localparam int unsigned EVT_USER       = 3;
  localparam int unsigned EVT_ERROR      = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h0_0;

  localparam int unsigned STATE_POS      = 0;
  localparam int unsigned SCHEME_POS     = 8;
  localparam int unsigned STRAP_POS      = 12;

  typedef enum logic [4:0] {
    CSC_POR    = 5'b0_0001,
    CSC_CLEAR  = 5'b0_0010,
    CSC_CONFIG = 5'b0_0100,
    CSC_USER   = 5'b0_1000,
    CSC_ERROR  = 5'b1_0000
  } csc_state_e;

  typedef struct packed {
    logic       por_fast;
    logic       pullup_off;
    logic [2:0] scheme;
  } csc_strap_s;

  localparam csc_strap_s STRAP_RESET = '{por_fast: 1'b0, pullup_off: 1'b0, scheme: 3'h0};
endpackage

// ==== tb.sv ====
// Purpose: self-checking bench for csc_config_start
// Assumes: shortened counts 20, 40 and 4 cycles
// Notes:   strap rows first, then hand-written cases
`timescale 1ns/1ps
module tb;
  import csc_pkg::*;
  localparam int PF = 20;
  localparam int PS = 40;
  localparam int DB = 4;
  typedef struct packed {
    logic       pf;
    logic       po;
    logic [2:0] sc;
    logic       pu;
    logic [5:0] por;
  } csc_row_s;
  csc_row_s rows [8] = '{'{1'b0, 1'b0, 3'h0, 1'b1, 6'(PS)}, '{1'b1, 1'b0, 3'h1, 1'b1, 6'(PF)},
                        '{1'b0, 1'b1, 3'h2, 1'b0, 6'(PS)}, '{1'b1, 1'b1, 3'h3, 1'b0, 6'(PF)},
                        '{1'b0, 1'b0, 3'h4, 1'b1, 6'(PS)}, '{1'b1, 1'b0, 3'h5, 1'b1, 6'(PF)},
                        '{1'b0, 1'b1, 3'h6, 1'b0, 6'(PS)}, '{1'b1, 1'b1, 3'h7, 1'b0, 6'(PF)}};
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        pf   = 1'b0;
  logic        po   = 1'b0;
  logic        jtag = 1'b0;
  logic        fin  = 1'b0;
  logic        sup  = 1'b1;
  logic        creq = 1'b1;
  logic        pl   = 1'b0;
  logic        we   = 1'b0;
  logic        re   = 1'b0;
  logic [2:0]  sc   = 3'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd   = 32'h0000_0000;
  logic [31:0] rdv;
  logic [31:0] rdd;
  logic [2:0]  cs;
  logic        cn, sin, so, soe, ce, cc, hz, pu, irq;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  int          n;

  always #2.5 clk = ~clk;

  csc_config_start #(.POR_FAST(PF), .POR_SLOW(PS), .DEB(DB)) csc_config_start_inst (
    .clk(clk), .srst(srst), .por_fast_sel(pf), .pullup_off_sel(po), .scheme_select(sc),
    .cfg_ctrl_n(cn), .jtag_mode(jtag), .cfg_finish(fin), .status_in(sin), .status_out(so),
    .status_oe(soe), .cfg_enable(ce), .cfg_clear(cc), .io_hiz(hz), .pullup_en(pu), .cfg_scheme(cs),
    .addr(addr), .wr_data(wd), .wr_en(we), .rd_en(re), .rd_data(rdd), .irq(irq));
  csc_host csc_host_inst (
    .supplies_ok(sup), .ctrl_req_n(creq), .pull_low(pl), .status_oe(soe), .status_out(so),
    .cfg_ctrl_n(cn), .status_in(sin));

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    we   <= 1'b1;
    @(posedge clk);
    we   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1;
    rdv = rdd;
  endtask

  // bounded wait: 0 watches cfg_enable, 1 cfg_clear
  task automatic wt(input int s, input logic v);
    for (n = 0; n < 300; n++) begin
      if ((s == 0 ? ce : cc) === v)
        break;
      tk(1);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    foreach (rows[i]) begin
      @(posedge clk);
      {pf, po, sc} <= {rows[i].pf, rows[i].po, rows[i].sc};
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      tk(5);
      chk(soe, 1'b1);
      chk(so, 1'b0);
      chk(ce, 1'b0);
      wt(0, 1'b1);
      chk(n + 5, rows[i].por);
      chk(soe, 1'b0);
      chk(cs, rows[i].sc);
      chk(pu, rows[i].pu);
    end
    $display("test strap rows done");
    rd(8'h00);
    chk(rdv, 32'h0000_0005);
    wr(8'h04, 32'h0000_0004);
    tk(1);
    chk(irq, 1'b1);
    wr(8'h00, 32'h0000_0005);
    tk(1);
    chk(irq, 1'b0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08);
    chk(rdv, 32'h0000_7704);
    tk(1);
    chk(rdd, 32'h0000_0000);
    rd(8'h10);
    chk(rdv, 32'h0000_0000);
    $display("test registers done");
    // a short dip must not reach the state machine
    @(posedge clk);
    creq <= 1'b0;
    repeat (2) @(posedge clk);
    creq <= 1'b1;
    tk(DB + 6);
    chk(ce, 1'b1);
    rd(8'h00);
    chk(rdv, 32'h0000_0000);
    @(posedge clk);
    jtag <= 1'b1;
    creq <= 1'b0;
    tk(3 * DB + 10);
    chk(ce, 1'b1);
    // control back high before jtag drops, so no restart is provoked
    @(posedge clk);
    creq <= 1'b1;
    tk(DB + 6);
    @(posedge clk);
    jtag <= 1'b0;
    rd(8'h00);
    chk(rdv, 32'h0000_0000);
    @(posedge clk);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    tk(1);
    chk(hz, 1'b0);
    $display("test control filter done");
    // supply dip pulls control low while in user operation
    @(posedge clk);
    sup <= 1'b0;
    wt(1, 1'b1);
    chk(n, DB + 3);
    chk(cc, 1'b1);
    chk(ce, 1'b0);
    chk(hz, 1'b1);
    tk(DB + 10);
    chk(ce, 1'b0);
    @(posedge clk);
    sup <= 1'b1;
    wt(0, 1'b1);
    chk(ce, 1'b1);
    chk(irq, 1'b1);
    @(posedge clk);
    pl <= 1'b1;
    wt(0, 1'b0);
    chk(soe, 1'b1);
    @(posedge clk);
    pl <= 1'b0;
    rd(8'h08);
    chk({27'h0, rdv[4:0]}, 32'h0000_0010);
    $display("test restart and error done");
    print_verdict();
  end
endmodule // tb
